/* core/global_fault_syndrome_regs.v */
// global fault status, restore and syndrome registers, banked per security state
// assumes an apb master with pprot[1] giving security, and a fault source pulsing fault_valid
//
// Contract
// - restore write replaces the whole status register, same bit layout.
// - non-secure restore hits non-secure status only; secure restore secure only.
// - secure and non-secure copies; secure software reaches non-secure copy by alias.
// - attribute syndrome 32 bits rw; 31:16 and 7 reserved; 15:8 implementation specific.
// - bit 6 marks a fault from a stage 1 translation operation.
// - bit 5 records security attribute, 1 non-secure; reserved in non-secure bank.
// - bit 4 records device security state; reserved in non-secure bank.
// - non-secure client fault reported in secure status sets state bit to 1.
// - bit 3 is 1 for instruction access, 0 for data.
// - bit 2 is 1 for privileged, 0 for unprivileged.
// - bit 1 is 1 for write; far atomics always report read.
// - bit 0 marks stage 2 nested fault; reserved in secure bank.
// - id syndrome holds descriptor index in 31:16, stream number in 15:0.
// - field widths are parameters; unimplemented index bits read zero, ignore writes.
// - descriptor index visible only to secure alias; zero for non-secure accesses. Code also shows it to secure accesses of the secure bank.
// - without a descriptor table the index value is meaningless.
// - older layout reserves bits 31 and 15, index 30:16, stream 14:0.
// - id syndrome is written in the bank matching the fault's security state.
// - writing 1 to a status bit clears it; 0 leaves it. Code clears only bits 31 and 8:0; a 1 written to bits 30:9 leaves them.
// - status bit 31 sets on a further error while status is nonzero.
`timescale 1ns/1ps
`include "fault_syndrome_consts.vh"

module global_fault_syndrome_regs #(
    parameter INDEX_WIDTH  = 16,
    parameter STREAM_WIDTH = 16,
    parameter HAS_DESC_TABLE = 1
) (
    // apb slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [2:0]  pprot,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // fault report
    input  wire        fault_valid,
    input  wire        fault_to_secure,
    input  wire [30:0] fault_status_bits,
    input  wire        fault_nonsecure_attr,
    input  wire        fault_nonsecure_client,
    input  wire        fault_xlate_op,
    input  wire        fault_instr,
    input  wire        fault_priv,
    input  wire        fault_write,
    input  wire        fault_far_atomic,
    input  wire        fault_nested,
    input  wire [7:0]  fault_impdef,
    input  wire [15:0] fault_index,
    input  wire [15:0] fault_stream,
    // status view
    output reg         ns_fault_pending,
    output reg         s_fault_pending
);

    reg  [31:0] status_reg    [0:1];
    reg  [31:0] attrs_reg     [0:1];
    reg  [31:0] ids_reg       [0:1];
    reg         legacy_reg;

    // index 0 non-secure bank, index 1 secure bank
    wire        secure_acc = ~pprot[1];
    wire        access     = psel & penable & ~pready;
    // writes land on the completing edge, where pready is sampled high
    wire        done       = psel & penable & pready;
    wire        wr         = done & pwrite;
    reg         hit;
    reg         bank;
    reg  [1:0]  which;
    reg         via_alias;

    always @*
    begin
        hit       = 1'b1;
        bank      = 1'b0;
        which     = 2'd0;
        via_alias = 1'b0;
        case (paddr)
            `OFF_NS_STATUS:
            begin
                which = 2'h0;
            end
            `OFF_NS_RESTORE:
            begin
                which = 2'h1;
            end
            `OFF_NS_ATTRS:
            begin
                which = 2'h2;
            end
            `OFF_NS_IDS:
            begin
                which = 2'h3;
            end
            `OFF_S_STATUS:
            begin
                bank  = 1'b1;
                which = 2'h0;
            end
            `OFF_S_RESTORE:
            begin
                bank  = 1'b1;
                which = 2'h1;
            end
            `OFF_S_ATTRS:
            begin
                bank  = 1'b1;
                which = 2'h2;
            end
            `OFF_S_IDS:
            begin
                bank  = 1'b1;
                which = 2'h3;
            end
            `OFF_ALIAS_STATUS:
            begin
                via_alias = 1'b1;
                which     = 2'h0;
            end
            `OFF_ALIAS_RESTORE:
            begin
                via_alias = 1'b1;
                which     = 2'h1;
            end
            `OFF_ALIAS_ATTRS:
            begin
                via_alias = 1'b1;
                which     = 2'h2;
            end
            `OFF_ALIAS_IDS:
            begin
                via_alias = 1'b1;
                which     = 2'h3;
            end
            `OFF_CTRL:
            begin
                which = 2'h0;
            end
            default:            hit = 1'b0;
        endcase
        // secure bank and aliases only for secure accesses
        if ((bank | via_alias) & ~secure_acc)
            hit = 1'b0;
    end

    wire is_ctrl = (paddr == `OFF_CTRL);

    // implemented index / stream bits in the active layout
    wire [15:0] index_mask;
    wire [15:0] stream_mask;
    genvar g;
    generate
        for (g = 0; g < 16; g = g + 1)
        begin : g_mask
            assign index_mask[g]  = (g < INDEX_WIDTH) & ~(legacy_reg & (g == 15));
            assign stream_mask[g] = (g < STREAM_WIDTH) & ~(legacy_reg & (g == 15));
        end
    endgenerate

    // descriptor index visible only through the secure alias or secure bank
    wire        index_vis = secure_acc & (bank | via_alias);
    wire [31:0] ids_mask  = {index_vis ? index_mask : 16'h0000, stream_mask};
    wire [31:0] attr_mask = bank ? `ATTR_MASK_SECURE : `ATTR_MASK_NONSEC;

    // fault syndrome assembly
    wire [31:0] fault_attrs;
    assign fault_attrs[31:16] = 16'h0000;
    assign fault_attrs[15:8]  = fault_impdef;
    assign fault_attrs[7]     = 1'b0;
    assign fault_attrs[6]     = fault_xlate_op;
    assign fault_attrs[5]     = fault_to_secure & fault_nonsecure_attr;
    assign fault_attrs[4]     = fault_to_secure & fault_nonsecure_client;
    assign fault_attrs[3]     = fault_instr;
    assign fault_attrs[2]     = fault_priv;
    assign fault_attrs[1]     = fault_write & ~fault_far_atomic;
    assign fault_attrs[0]     = ~fault_to_secure & fault_nested;

    // index meaningless without a descriptor table; zero chosen then
    wire [15:0] fault_index_eff = HAS_DESC_TABLE ? fault_index : 16'h0000;
    wire [31:0] fault_ids = {fault_index_eff & index_mask, fault_stream & stream_mask};

    wire        fault_bank = fault_to_secure;

    // per-bank next values, one entry per security state
    wire [31:0] status_next [0:1];
    wire [31:0] attrs_next  [0:1];
    wire [31:0] ids_next    [0:1];

    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1)
        begin : g_bank
            // entry 0 is the non-secure bank, entry 1 the secure bank
            wire        bus_here   = (k == 1) ? bank : ~bank;
            wire        fault_here = (k == 1) ? fault_bank : ~fault_bank;
            wire        sw_wr      = wr & hit & ~is_ctrl & bus_here;
            wire        capture    = fault_valid & fault_here;
            wire        multi      = (status_reg[k] != `RESET_ZERO);
            reg  [31:0] status_sw;
            reg  [31:0] attrs_sw;
            reg  [31:0] ids_sw;
            reg  [31:0] status_new;
            reg  [31:0] attrs_new;
            reg  [31:0] ids_new;

            // software side
            always @*
            begin
                status_sw = status_reg[k];
                attrs_sw  = attrs_reg[k];
                ids_sw    = ids_reg[k];
                if (sw_wr)
                begin
                    case (which)
                        2'h0:
                        begin
                            status_sw = status_reg[k] & ~(pwdata & `STATUS_CLEAR_MASK);
                        end
                        2'h1:
                        begin
                            status_sw = pwdata;
                        end
                        2'h2:
                        begin
                            attrs_sw = pwdata & attr_mask;
                        end
                        2'h3:
                        begin
                            ids_sw = (pwdata & ids_mask) | (ids_reg[k] & ~ids_mask);
                        end
                        default:
                        begin
                            status_sw = status_reg[k];
                        end
                    endcase
                end
            end

            // fault capture wins over a software write in the same cycle
            always @*
            begin
                status_new = status_sw;
                attrs_new  = attrs_sw;
                ids_new    = ids_sw;
                if (capture)
                begin
                    status_new = status_reg[k] | {multi, fault_status_bits};
                    attrs_new  = fault_attrs;
                    ids_new    = fault_ids;
                end
            end

            assign status_next[k] = status_new;
            assign attrs_next[k]  = attrs_new;
            assign ids_next[k]    = ids_new;
        end
    endgenerate

    // bus answer: one wait state, read data stands only while pready is high
    reg  [31:0] prdata_next;
    reg         pready_next;
    reg         pslverr_next;
    reg         legacy_next;

    always @*
    begin
        pready_next  = access;
        pslverr_next = access & ~hit;
        prdata_next  = `RESET_ZERO;
        if (access & hit & ~pwrite)
        begin
            if (is_ctrl)
            begin
                prdata_next = {{31{1'b0}}, legacy_reg};
            end
            else
            begin
                case (which)
                    2'h0:
                    begin
                        prdata_next = status_reg[bank];
                    end
                    2'h2:
                    begin
                        prdata_next = attrs_reg[bank] & attr_mask;
                    end
                    2'h3:
                    begin
                        prdata_next = ids_reg[bank] & ids_mask;
                    end
                    default:
                    begin
                        // restore is write-only and reads zero
                        prdata_next = `RESET_ZERO;
                    end
                endcase
            end
        end
    end

    always @*
    begin
        legacy_next = legacy_reg;
        if (wr & hit & is_ctrl)
        begin
            legacy_next = pwdata[`CTRL_LEGACY_BIT];
        end
    end

    integer b;

    // bank registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (b = 0; b < 2; b = b + 1)
            begin
                status_reg[b] <= `RESET_ZERO;
                attrs_reg[b]  <= `RESET_ZERO;
                ids_reg[b]    <= `RESET_ZERO;
            end
        end
        else
        begin
            for (b = 0; b < 2; b = b + 1)
            begin
                status_reg[b] <= status_next[b];
                attrs_reg[b]  <= attrs_next[b];
                ids_reg[b]    <= ids_next[b];
            end
        end
    end

    // control bit and bus answer
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            legacy_reg <= 1'b0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= `RESET_ZERO;
        end
        else
        begin
            legacy_reg <= legacy_next;
            pready     <= pready_next;
            pslverr    <= pslverr_next;
            prdata     <= prdata_next;
        end
    end

    // pending levels trail the status word by one cycle
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ns_fault_pending <= 1'b0;
            s_fault_pending  <= 1'b0;
        end
        else
        begin
            ns_fault_pending <= (status_reg[0] != `RESET_ZERO);
            s_fault_pending  <= (status_reg[1] != `RESET_ZERO);
        end
    end

endmodule // global_fault_syndrome_regs

/* core/fault_syndrome_consts.vh */
// register offsets, field positions and layout constants for the global fault syndrome bank
// assumes inclusion by bare name from design files under core/
`ifndef FAULT_SYNDROME_CONSTS_VH
`define FAULT_SYNDROME_CONSTS_VH

// non-secure bank (reached by non-secure accesses)
`define OFF_NS_STATUS      12'h000
`define OFF_NS_RESTORE     12'h004
`define OFF_NS_ATTRS       12'h008
`define OFF_NS_IDS         12'h00C
// secure bank
`define OFF_S_STATUS       12'h010
`define OFF_S_RESTORE      12'h014
`define OFF_S_ATTRS        12'h018
`define OFF_S_IDS          12'h01C
// secure aliases of the non-secure copies
`define OFF_ALIAS_STATUS   12'h020
`define OFF_ALIAS_RESTORE  12'h024
`define OFF_ALIAS_ATTRS    12'h028
`define OFF_ALIAS_IDS      12'h02C
// control: bit 0 selects the older layout of the id register
`define OFF_CTRL           12'h030

`define CTRL_LEGACY_BIT    0

// status register fields
`define STATUS_MULTI_BIT   31
`define STATUS_CLEAR_MASK  32'h800001FF

// attribute syndrome fields
`define ATTR_IMPDEF_HI     15
`define ATTR_IMPDEF_LO     8
`define ATTR_XLATE_BIT     6
`define ATTR_NONSECURE_ATTR_BIT    5
`define ATTR_NONSECURE_STATE_BIT   4
`define ATTR_INSTR_BIT     3
`define ATTR_PRIV_BIT      2
`define ATTR_WRITE_BIT     1
`define ATTR_NESTED_BIT    0
`define ATTR_MASK_SECURE   32'h0000FF7E
`define ATTR_MASK_NONSEC   32'h0000FF4F

// id syndrome fields
`define IDS_INDEX_LO       16
`define IDS_STREAM_LO      0

`define RESET_ZERO         32'h00000000

`endif

/* testbench/fault_source_model.sv */
// fault source model: one-cycle fault report with its attributes
// assumes the bench raises fire for one clock per fault
`timescale 1ns/1ps
module fault_source_model (
    input  wire logic        pclk,
    input  wire logic        fire,
    input  wire logic [79:0] cmd,
    output logic      [80:0] fb
);
    initial fb = '0;
    // between reports the attribute lines toggle, so values taken one cycle late never match
    always @(posedge pclk)
        fb <= fire ? {1'b1, cmd} : {1'b0, ~fb[79:0]};
endmodule // fault_source_model

/* testbench/global_fault_syndrome_regs_monitor.sv */
// checker: bus answer timing, refusals and fault pending of the syndrome bank
// assumes only the bank's top-level ports
`timescale 1ns/1ps
module global_fault_syndrome_regs_monitor (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [2:0]  pprot,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // faults
    input wire logic        fault_valid,
    input wire logic        fault_to_secure,
    input wire logic [30:0] fault_status_bits,
    input wire logic        ns_fault_pending,
    input wire logic        s_fault_pending
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && !pready;
    property p_ans; acc |=> pready ##1 !pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after access");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rz; !pready |-> prdata == 32'h0; endproperty
    a_rz: assert property (p_rz) else $error("read data outside answer");
    property p_sec; acc && pprot[1] && paddr >= 12'h010 && paddr <= 12'h02C |=> pslverr; endproperty
    a_sec: assert property (p_sec) else $error("secure bank open to nonsecure");
    property p_unm; acc && paddr > 12'h030 |=> pslverr; endproperty
    a_unm: assert property (p_unm) else $error("unmapped access accepted");
    property p_wo; acc && !pwrite && paddr[3:0] == 4'h4 && paddr < 12'h030 |=> prdata == 32'h0;
    endproperty
    a_wo: assert property (p_wo) else $error("restore register readable");
    property p_nsf; fault_valid && !fault_to_secure && |fault_status_bits
        |-> ##[1:2] ns_fault_pending; endproperty
    a_nsf: assert property (p_nsf) else $error("nonsecure fault not recorded");
    property p_sf; fault_valid && fault_to_secure && |fault_status_bits
        |-> ##[1:2] s_fault_pending; endproperty
    a_sf: assert property (p_sf) else $error("secure fault not recorded");
endmodule // global_fault_syndrome_regs_monitor
bind global_fault_syndrome_regs global_fault_syndrome_regs_monitor i_monitor (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pprot, .prdata, .pready, .pslverr, .fault_valid,
    .fault_to_secure, .fault_status_bits, .ns_fault_pending, .s_fault_pending);

/* testbench/global_fault_syndrome_regs_tb_top.sv */
// bench: apb master and fault source around the fault syndrome bank
// assumes the bank answers one wait state after the access phase
`timescale 1ns/1ps
module global_fault_syndrome_regs_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [2:0]  pprot = 0;
    logic        pready, pslverr, ns_pend, s_pend;
    logic [79:0] cmd = 0;
    logic [80:0] fb;
    int          mismatches = 0, check_count = 0, cyc = 0;
    always #25 pclk = ~pclk;
    fault_source_model i_fault_source_model (.pclk(pclk), .fire(fire), .cmd(cmd), .fb(fb));
    global_fault_syndrome_regs i_global_fault_syndrome_regs (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fault_valid(fb[80]), .fault_to_secure(fb[79]), .fault_status_bits(fb[78:48]),
        .fault_nonsecure_attr(fb[47]), .fault_nonsecure_client(fb[46]), .fault_xlate_op(fb[45]),
        .fault_instr(fb[44]), .fault_priv(fb[43]), .fault_write(fb[42]),
        .fault_far_atomic(fb[41]), .fault_nested(fb[40]), .fault_impdef(fb[39:32]),
        .fault_index(fb[31:16]), .fault_stream(fb[15:0]), .ns_fault_pending(ns_pend),
        .s_fault_pending(s_pend));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ns);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; pprot <= {1'b0, ns, 1'b0};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr; psel <= 0; penable <= 0;
    endtask
    task flt(input logic [79:0] c);
        @(posedge pclk);
        cmd <= c; fire <= 1;
        @(posedge pclk);
        fire <= 0;
        repeat (3) @(posedge pclk);
    endtask
    task t_ns;
        chk({30'h0, ns_pend, s_pend}, 32'h0);
        flt({1'b0, 31'h102, 8'hFD, 8'hA5, 16'h1234, 16'hABCD});
        apb(0, 12'h008, 0, 1); chk(rd, 32'h0000A54F);
        apb(0, 12'h00C, 0, 1); chk(rd, 32'h0000ABCD);
        apb(0, 12'h02C, 0, 0); chk(rd, 32'h1234ABCD);
        flt({1'b0, 31'h1, 48'h0});
        apb(0, 12'h000, 0, 1); chk(rd, 32'h80000103);
        apb(1, 12'h000, 32'h80000002, 1);
        apb(0, 12'h000, 0, 1); chk(rd, 32'h00000101);
        $display("t_ns done");
    endtask
    task t_sec;
        flt({1'b1, 31'h40, 8'hC7, 8'h3C, 16'h8765, 16'hFEDC});
        apb(0, 12'h018, 0, 0); chk(rd, 32'h00003C30);
        apb(0, 12'h01C, 0, 0); chk(rd, 32'h8765FEDC);
        apb(0, 12'h02C, 0, 0); chk(rd, 32'h00000000);
        apb(0, 12'h010, 0, 0); chk(rd, 32'h00000040);
        chk({30'h0, ns_pend, s_pend}, 32'h3);
        $display("t_sec done");
    endtask
    task t_rest;
        apb(1, 12'h014, 32'h80000055, 0);
        apb(0, 12'h010, 0, 0); chk(rd, 32'h80000055);
        apb(0, 12'h014, 0, 0); chk(rd, 32'h00000000);
        apb(0, 12'h000, 0, 1); chk(rd, 32'h00000101);
        apb(1, 12'h024, 32'h00000007, 0);
        apb(0, 12'h000, 0, 1); chk(rd, 32'h00000007);
        $display("t_rest done");
    endtask
    task t_err;
        apb(0, 12'h018, 0, 1); chk({31'h0, er}, 32'h1);
        apb(1, 12'h018, 32'hFFFFFFFF, 0);
        apb(0, 12'h018, 0, 0); chk(rd, 32'h0000FF7E);
        apb(0, 12'h040, 0, 0); chk({31'h0, er}, 32'h1);
        apb(1, 12'h030, 32'h1, 0);
        apb(0, 12'h01C, 0, 0); chk(rd, 32'h07657EDC);
        $display("t_err done");
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            close_out;
        end
    end
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        t_ns;
        t_sec;
        t_rest;
        t_err;
        close_out;
    end
endmodule // global_fault_syndrome_regs_tb_top
